// >>> hsp_dev_model.sv
/* Behavioural model of the sensor serial port and its registers.
 Assumes the wire level is resolved by the bench. */
`timescale 1ns/100ps
module hsp_dev_model
#(
   parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary value
)
(
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sda,
   output logic dev_do,
   output logic dev_oe
);
   logic [7:0] mem [64];
   logic [7:0] sh;
   logic rd, inc;
   logic [5:0] idx;
   int cnt;
   // Power-on contents; outputs and calibration hold a fixed pattern
   initial
   begin
      foreach (mem[i]) mem[i] = 8'(i * 37 + 11);
      mem[6'h0f] = ID_CODE;
      mem[6'h10] = 8'h1b;
      mem[6'h20] = 8'h00;
      mem[6'h21] = 8'h00;
      mem[6'h22] = 8'h00;
      mem[6'h27] = 8'h00;
      dev_oe = 1'b0;
      dev_do = 1'b0;
      cnt = 0;
   end
   // Bits count from the select fall; a partial byte is never stored
   always @(negedge cs_n) cnt = 0;
   always @(posedge cs_n) dev_oe = 1'b0;
   // Sample on rising edges: command, then whole bytes
   always @(posedge sclk)
   begin
      if (!cs_n)
      begin
         sh = {sh[6:0], sda};
         cnt++;
         if (cnt == 8) {rd, inc, idx} = sh;
         else if (cnt % 8 == 0)
         begin
            // Read-only places ignore writes
            if (!rd && idx != 6'h0f && !(idx >= 6'h27 && idx <= 6'h2b)) mem[idx] = sh;
            if (inc) idx++;
         end
      end
   end
   // Drive read data on falling edges, MSB first
   always @(negedge sclk)
   begin
      if (!cs_n && rd && cnt >= 8)
      begin
         dev_oe = 1'b1;
         dev_do = mem[idx][7 - cnt % 8];
      end
   end
endmodule

// >>> hsp_host.sv
/*
 Host controller that drives a three-wire serial sensor port: chip select,
 serial clock and one shared data line. Takes a register access order from
 the user (read or write, auto-increment, index, byte count) and runs one frame.
 Assumes the user ports are synchronous to clk and that the wire level of the
 shared data line is resolved outside from the output enable.
*/
`timescale 1ns/100ps

// Contract
// - Select low begins, high ends transaction
// - Clock parked high while select high
// - Change data on fall, sample on rise
// - Sixteen pulses plus eight per extra byte
// - Bits begin at falling clock edges
// - First bit zero writes, one reads
// - Second bit enables index auto-increment
// - Bits two to seven carry index
// - Write data sent MSB first after command
// - Never write reserved address ranges
// - Calibration registers never written by host
// - Host sets hold bit for safe reads; this host never sets it itself
module hsp_host
   import hsp_pkg::*;
#(
   parameter int MAX_BYTES = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // User order
   input wire logic start,
   input wire logic read_not_write,
   input wire logic auto_increment_bit,
   input wire logic [5:0] reg_index,
   input wire logic [4:0] byte_count,
   input wire logic [7:0] write_byte,
   // User answer
   output logic write_taken,
   output logic [7:0] read_byte,
   output logic read_valid,
   output logic busy,
   output logic done,
   output logic refused,
   // Sensor pins
   output logic cs_n,
   output logic serial_clock_pin,
   output logic data_out,
   output logic data_oe_n,
   input wire logic data_in
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD} hsp_state_e;

   typedef struct packed {
      hsp_state_e state;
      logic [7:0] half_cnt;
      logic [2:0] bit_cnt;
      logic [4:0] bytes_left;
      logic in_cmd;
      logic rd;
      logic [7:0] shift;
      logic [7:0] rx;
      logic write_taken;
      logic [7:0] read_byte;
      logic read_valid;
      logic busy;
      logic done;
      logic refused;
      logic cs_n;
      logic sclk;
      logic dout;
      logic oe_n;
   } hsp_regs_s;

   hsp_regs_s q;
   hsp_regs_s d;
   logic bad_target;

   // Writes to reserved ranges or calibration damage the part; the identity
   // and output registers are read only, so such writes are refused.
   always_comb
   begin
      bad_target = 1'b0;
      if (reg_index < ADDR_IDENT) bad_target = 1'b1;
      if (reg_index > ADDR_AVG_CFG && reg_index < ADDR_CTRL_ONE) bad_target = 1'b1;
      if (reg_index > ADDR_CTRL_THREE) bad_target = 1'b1;
      if (reg_index == ADDR_IDENT) bad_target = 1'b1;
      // A multi-byte write that runs past the control block is refused too
      if (auto_increment_bit && byte_count > 5'd1
          && ({1'b0, reg_index} + 7'(byte_count) - 7'd1) > {1'b0, ADDR_CTRL_THREE}
          && reg_index >= ADDR_CTRL_ONE)
         bad_target = 1'b1;
      if (auto_increment_bit && byte_count > 5'd1 && reg_index == ADDR_AVG_CFG)
         bad_target = 1'b1;
   end

   // Next state of the whole controller
   always_comb
   begin
      d = q;
      d.write_taken = 1'b0;
      d.read_valid = 1'b0;
      d.done = 1'b0;
      d.refused = 1'b0;
      case (q.state)
         ST_IDLE:
         begin
            d.cs_n = 1'b1;
            d.sclk = 1'b1;
            d.oe_n = 1'b1;
            if (start)
            begin
               if (byte_count == 5'd0 || byte_count > 5'(MAX_BYTES)
                   || (!read_not_write && bad_target))
                  d.refused = 1'b1;
               else
               begin
                  // Command byte: direction, increment, index
                  d.shift = {read_not_write, auto_increment_bit, reg_index};
                  d.rd = read_not_write;
                  d.bytes_left = byte_count;
                  d.in_cmd = 1'b1;
                  d.bit_cnt = 3'd0;
                  d.cs_n = 1'b0;
                  d.busy = 1'b1;
                  d.half_cnt = 8'(CS_GAP_CYC - 1);
                  d.state = ST_SETUP;
               end
            end
         end
         ST_SETUP:
         begin
            if (q.half_cnt != 8'd0)
               d.half_cnt = q.half_cnt - 8'd1;
            else
            begin
               // Falling edge opens each bit; sender drives here
               d.sclk = 1'b0;
               d.oe_n = !(q.in_cmd || !q.rd) ? 1'b1 : 1'b0;
               d.dout = q.shift[7];
               d.half_cnt = 8'(HALF_CYC - 1);
               d.state = ST_LOW;
            end
         end
         ST_LOW:
         begin
            if (q.half_cnt != 8'd0)
               d.half_cnt = q.half_cnt - 8'd1;
            else
            begin
               // Rising edge: receiver samples
               d.sclk = 1'b1;
               if (!q.in_cmd && q.rd)
                  d.rx = {q.rx[6:0], data_in};
               d.half_cnt = 8'(HALF_CYC - 1);
               d.state = ST_HIGH;
            end
         end
         ST_HIGH:
         begin
            if (q.half_cnt != 8'd0)
               d.half_cnt = q.half_cnt - 8'd1;
            else
            begin
               d.shift = {q.shift[6:0], 1'b0};
               d.bit_cnt = q.bit_cnt + 3'd1;
               d.half_cnt = 8'(HALF_CYC - 1);
               if (q.bit_cnt == 3'(BYTE_BITS - 1))
               begin
                  // Byte boundary: eight more pulses per extra byte
                  if (!q.in_cmd)
                  begin
                     d.bytes_left = q.bytes_left - 5'd1;
                     if (q.rd)
                     begin
                        d.read_byte = q.rx;
                        d.read_valid = 1'b1;
                     end
                  end
                  d.in_cmd = 1'b0;
                  if (!q.in_cmd && q.bytes_left == 5'd1)
                  begin
                     d.oe_n = 1'b1;
                     d.half_cnt = 8'(CS_GAP_CYC - 1);
                     d.state = ST_HOLD;
                  end
                  else
                  begin
                     // Load next data byte; the device advances its own index when auto-increment is set
                     if (!q.rd)
                     begin
                        d.shift = write_byte;
                        d.write_taken = 1'b1;
                     end
                     d.sclk = 1'b0;
                     d.oe_n = q.rd ? 1'b1 : 1'b0;
                     d.dout = q.rd ? 1'b0 : write_byte[7];
                     d.state = ST_LOW;
                  end
               end
               else
               begin
                  d.sclk = 1'b0;
                  d.dout = q.shift[6];
                  d.state = ST_LOW;
               end
            end
         end
         ST_HOLD:
         begin
            if (q.half_cnt != 8'd0)
               d.half_cnt = q.half_cnt - 8'd1;
            else
            begin
               d.cs_n = 1'b1;
               d.busy = 1'b0;
               d.done = 1'b1;
               d.state = ST_IDLE;
            end
         end
         default:
         begin
            d.state = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
         q.state <= ST_IDLE;
         q.cs_n <= 1'b1;
         q.sclk <= 1'b1;
         q.oe_n <= 1'b1;
      end
      else
         q <= d;
   end

   assign write_taken = q.write_taken;
   assign read_byte = q.read_byte;
   assign read_valid = q.read_valid;
   assign busy = q.busy;
   assign done = q.done;
   assign refused = q.refused;
   assign cs_n = q.cs_n;
   assign serial_clock_pin = q.sclk;
   assign data_out = q.dout;
   assign data_oe_n = q.oe_n;
endmodule

// >>> hsp_pkg.sv
/*
 Package for the sensor serial port host controller: register map, field
 positions, reset values and frame timing constants.
 Assumes a 10 MHz system clock and a three-wire serial sensor port.
*/
package hsp_pkg;
   // Register offsets of the device
   localparam logic [5:0] ADDR_IDENT = 6'h0f;
   localparam logic [5:0] ADDR_AVG_CFG = 6'h10;
   localparam logic [5:0] ADDR_CTRL_ONE = 6'h20;
   localparam logic [5:0] ADDR_CTRL_TWO = 6'h21;
   localparam logic [5:0] ADDR_CTRL_THREE = 6'h22;
   localparam logic [5:0] ADDR_STATUS = 6'h27;
   localparam logic [5:0] ADDR_HUM_LOW = 6'h28;
   localparam logic [5:0] ADDR_HUM_HIGH = 6'h29;
   localparam logic [5:0] ADDR_TEMP_LOW = 6'h2a;
   localparam logic [5:0] ADDR_TEMP_HIGH = 6'h2b;
   localparam logic [5:0] ADDR_CALIB = 6'h30;
   // Reset values of the device registers
   localparam logic [7:0] RST_AVG_CFG = 8'h1b;
   localparam logic [7:0] RST_CTRL = 8'h00;
   // Field positions
   localparam int POS_TEMP_AVG = 3;
   localparam int POS_HUM_AVG = 0;
   localparam int POS_POWER = 7;
   localparam int POS_HOLD = 2;
   localparam int POS_RATE = 0;
   localparam int POS_ONE_SHOT = 0;
   // Frame layout
   localparam int CMD_BITS = 8;
   localparam int BYTE_BITS = 8;
   localparam logic CMD_WRITE = 1'b0;
   localparam logic CMD_READ = 1'b1;
   // Timing: half serial clock period
   localparam int CLK_HZ = 10000000;
   localparam int HALF_PERIOD_NS = 500;
   localparam int HALF_CYC = (HALF_PERIOD_NS * (CLK_HZ / 1000000) + 999) / 1000;
   // Chip select setup and hold around the clock bursts
   localparam int CS_GAP_NS = 500;
   localparam int CS_GAP_CYC = (CS_GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
endpackage

// >>> hsp_props.sv
/* Assertions on the host pins and user flags.
 Bound to hsp_host from tb_top; sees only its ports. */
`timescale 1ns/100ps
module hsp_props
   import hsp_pkg::*;
#(
   parameter int MAX_BYTES = 16
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // User flags
   input wire logic busy,
   input wire logic done,
   input wire logic refused,
   input wire logic read_valid,
   // Sensor pins
   input wire logic cs_n,
   input wire logic serial_clock_pin,
   input wire logic data_out,
   input wire logic data_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Pin timing over a frame; one bit is ten cycles
   idle_clock_a: assert property (cs_n |-> serial_clock_pin)
      else $error("clock not parked high");
   idle_float_a: assert property (cs_n |-> data_oe_n)
      else $error("line driven while idle");
   sel_open_a: assert property ($rose(busy) |-> !cs_n)
      else $error("select not low at start");
   first_fall_a: assert property ($fell(cs_n) |-> serial_clock_pin[*5] ##1 !serial_clock_pin)
      else $error("first fall misplaced");
   half_bit_a: assert property ($fell(serial_clock_pin) |-> !serial_clock_pin[*5] ##1 serial_clock_pin)
      else $error("low half wrong");
   data_edge_a: assert property (!data_oe_n && !$past(data_oe_n) && $changed(data_out)
      |-> $fell(serial_clock_pin)) else $error("data moved off falling edge");
   sel_close_a: assert property ($rose(cs_n) |-> done && !busy)
      else $error("frame end mismatch");
   read_release_a: assert property (read_valid |-> data_oe_n && !cs_n)
      else $error("line not released on read");
   refuse_idle_a: assert property (refused |-> cs_n && !busy)
      else $error("refused order started");
endmodule

// >>> tb_top.sv
/* Self-checking bench for the sensor port host controller.
 Uses hsp_dev_model as the far side and hsp_props as checker. */
`timescale 1ns/100ps
module tb_top;
   import hsp_pkg::*;
   localparam logic [7:0] ID = 8'h5a;
   logic clk = 0, rst = 1, start = 0, rnw = 0, inc = 0, last = 0;
   logic [5:0] idx = 0;
   logic [4:0] cnt = 0;
   logic [7:0] wb = 0, rb, keep, wq [16], rq [$];
   logic wt, rv, busy, done, refd, cs_n, sclk, dout, oe_n, dev_do, dev_oe;
   int err_total = 0, samples_checked = 0, wi, cyc = 0;
   // Released line shows a toggling level, never the stale bit
   wire line = !oe_n ? dout : dev_oe ? dev_do : ~last;
   always #50 clk = ~clk;
   always @(posedge clk) last <= line;
   hsp_host hsp_host_inst(.clk, .rst, .start, .read_not_write(rnw), .auto_increment_bit(inc),
      .reg_index(idx), .byte_count(cnt), .write_byte(wb), .write_taken(wt), .read_byte(rb),
      .read_valid(rv), .busy, .done, .refused(refd), .cs_n, .serial_clock_pin(sclk),
      .data_out(dout), .data_oe_n(oe_n), .data_in(line));
   hsp_dev_model #(.ID_CODE(ID)) hsp_dev_model_inst(.cs_n, .sclk, .sda(line), .dev_do, .dev_oe);
   // Feed next write byte and collect read bytes
   always @(negedge clk)
   begin
      if (wt) wb <= wq[wi++];
      if (rv) rq.push_back(rb);
   end
   // Hang guard
   always @(posedge clk) if (++cyc == 60000) begin err_total++; stop_test; end
   task stop_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task check8(string n, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin err_total++; $display("ERROR %s exp %h got %h", n, e, g); end
   endtask
   // Orders the host must accept: no damaging or calibration writes
   function bit legal(logic r, logic i, logic [5:0] a, logic [4:0] n);
      int e;
      e = a + (i ? n - 1 : 0);
      return n != 0 && n <= 16 && (r || (a == 6'h10 && e == 16) || (a >= 6'h20 && e <= 34));
   endfunction
   task frame(logic r, logic i, logic [5:0] a, logic [4:0] n);
      int k;
      @(negedge clk);
      {rnw, inc, idx, cnt, wb, wi, start} = {r, i, a, n, wq[0], 32'd1, 1'b1};
      rq = {};
      @(negedge clk);
      start = 0;
      check8("refused", {7'h0, !legal(r, i, a, n)}, {7'h0, refd});
      for (k = 0; k < 3000 && legal(r, i, a, n) && done !== 1'b1; k++) @(negedge clk);
      if (legal(r, i, a, n)) check8("done", 8'h01, {7'h0, done});
   endtask
   initial
   begin
      void'($urandom(61744));
      repeat (8) @(negedge clk);
      rst = 0;
      frame(1, 0, ADDR_IDENT, 4);
      for (int k = 0; k < 4; k++) check8("ident", ID, rq[k]);
      frame(1, 0, ADDR_AVG_CFG, 1);
      check8("avg_rst", RST_AVG_CFG, rq[0]);
      frame(1, 1, ADDR_CTRL_ONE, 3);
      for (int k = 0; k < 3; k++) check8("ctrl_rst", RST_CTRL, rq[k]);
      // Every rate code, random power and hold bits
      for (int j = 0; j < 8; j++)
      begin
         foreach (wq[k]) wq[k] = 8'($urandom);
         wq[0][1:0] = j[1:0];
         frame(0, 1, ADDR_CTRL_ONE, 3);
         frame(1, 1, ADDR_CTRL_ONE, 3);
         for (int k = 0; k < 3; k++) check8("ctrl_rd", wq[k], rq[k]);
      end
      frame(0, 0, ADDR_AVG_CFG, 2);
      frame(1, 0, ADDR_AVG_CFG, 1);
      check8("avg_fix", wq[1], rq[0]);
      keep = wq[1];
      // Damaging and malformed orders
      foreach (wq[k]) wq[k] = 8'hff;
      frame(0, 0, ADDR_IDENT, 1);
      frame(0, 0, ADDR_CALIB, 1);
      frame(0, 0, 6'h23, 1);
      frame(0, 1, ADDR_CTRL_TWO, 3);
      frame(0, 1, ADDR_AVG_CFG, 2);
      frame(1, 0, ADDR_STATUS, 0);
      frame(1, 0, ADDR_STATUS, 17);
      frame(1, 0, ADDR_AVG_CFG, 1);
      check8("avg_kept", keep, rq[0]);
      frame(1, 0, ADDR_IDENT, 1);
      check8("ident_kept", ID, rq[0]);
      stop_test;
   end
endmodule
bind hsp_host hsp_props #(.MAX_BYTES(MAX_BYTES)) hsp_props_inst(.clk, .rst, .busy, .done,
   .refused, .read_valid, .cs_n, .serial_clock_pin, .data_out, .data_oe_n);
